// [shared/dmd_pkg.sv]
// Constants and types shared by the data memory address decoder files.
// Assumes an 8-bit core with a byte-wide data space and a sectored program flash.
`default_nettype none

package dmd_pkg;

	// ==================================================================
	// Internal data RAM layout.
	localparam int DW = 8;
	localparam int RAM_AW = 8;
	localparam int HALF_BIT = 7;
	localparam int SFR_AW = 7;
	localparam int REG_W = 3;
	localparam int BANK_W = 2;
	localparam int BANK_PAD_W = RAM_AW - BANK_W - REG_W;
	localparam logic [7:0] BANK_TOP = 8'h20;
	localparam logic [7:0] BIT_BASE = 8'h20;
	localparam logic [7:0] BIT_TOP = 8'h30;
	localparam logic [7:0] BIT_SFR_MASK = 8'hF8;
	localparam logic [7:0] BIT_ONE = 8'h01;
	localparam int BIT_IDX_W = 3;

	// ==================================================================
	// Program flash layout.
	localparam int FLASH_AW = 13;
	localparam logic [13:0] FLASH_BYTES_MAX = 14'h2000;
	localparam int SECTOR_SHIFT = 9;
	localparam int SECTOR_W = FLASH_AW - SECTOR_SHIFT;

	// ==================================================================
	// Access modes from the core and sequencer states.
	typedef enum logic [1:0] {ACC_DIRECT, ACC_INDIRECT, ACC_REG, ACC_BIT} dmd_mode_t;
	typedef enum logic [2:0] {ST_IDLE, ST_ACC, ST_READ, ST_WB, ST_RESP} dmd_state_t;

endpackage

`default_nettype wire

// [hdl/dmd_ram.sv]
// Single-port internal data RAM with a registered read port.
// Assumes one access per cycle; read data appear the cycle after the enable.
`default_nettype none
`timescale 1ns/1ns

module dmd_ram #(
	parameter int DW = dmd_pkg::DW,
	parameter int AW = dmd_pkg::RAM_AW
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Access port.
	input wire logic en,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata_r
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	// ==================================================================
	// Storage array; left without reset so it maps onto plain RAM cells.
	always_ff @(posedge clk)
	begin
		if (en && we)
		begin
			mem[addr] <= wdata;
		end
	end

	// Read register; reset so the output is defined before the first read.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdata_r <= '0;
		end
		else if (en && !we)
		begin
			rdata_r <= mem[addr];
		end
	end

endmodule

`default_nettype wire

// [hdl/dmd_decoder.sv]
// Data memory address decoder: routes core operand accesses to RAM or SFR space,
// handles banked registers and bit access, and gates flash sector erases.
// Assumes the core holds a request until ready and the SFR space answers one cycle late.
//
// Functional notes
// - Internal RAM holds 256 bytes, two halves.
// - Indirect upper-half access goes to upper RAM.
// - Direct upper-half access goes to SFR space.
// - Lower half: direct and indirect reach RAM.
// - Lowest 32 bytes form four register banks.
// - Next 16 bytes are bit addressable too.
// - Flash erases only in whole 512-byte sectors.
`default_nettype none
`timescale 1ns/1ns

module dmd_decoder #(
	parameter logic [13:0] FLASH_BYTES = dmd_pkg::FLASH_BYTES_MAX
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Core access request.
	input wire logic acc_valid,
	output logic acc_ready,
	input wire dmd_pkg::dmd_mode_t acc_mode,
	input wire logic [7:0] acc_addr,
	input wire logic [2:0] acc_reg,
	input wire logic acc_write,
	input wire logic [7:0] acc_wdata,
	input wire logic acc_wbit,
	// Bank select from the processor status.
	input wire logic [1:0] bank_sel,
	// Access response.
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_bit,
	output logic rsp_sfr,
	output logic rsp_in_bank,
	output logic rsp_in_bitarea,
	// Special function register space.
	output logic sfr_re,
	output logic sfr_we,
	output logic [6:0] sfr_addr,
	output logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	// Flash sector erase.
	input wire logic fl_erase_req,
	input wire logic [12:0] fl_erase_addr,
	output logic fl_erase_go,
	output logic [3:0] fl_erase_sector,
	output logic fl_erase_err
);

	// ==================================================================
	// Access sequencer state.
	dmd_pkg::dmd_state_t state_r, state_nxt;
	logic [7:0] phys_r, phys_nxt;
	logic sfr_r, sfr_nxt, bitop_r, bitop_nxt, write_r, write_nxt;
	logic [2:0] bidx_r, bidx_nxt;
	logic bval_r, bval_nxt, bank_r, bank_nxt, bitarea_r, bitarea_nxt;
	logic [7:0] wdata_r, wdata_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic take, ram_en, ram_we;
	logic [7:0] ram_rdata, rd_byte, bit_mask;

	assign take = acc_valid && (state_r == dmd_pkg::ST_IDLE);
	assign rd_byte = sfr_r ? sfr_rdata : ram_rdata;
	assign bit_mask = dmd_pkg::BIT_ONE << bidx_r;

	// Decode the address on acceptance, then walk read, modify and write back.
	always_comb
	begin
		state_nxt = state_r;
		phys_nxt = phys_r;
		sfr_nxt = sfr_r;
		bitop_nxt = bitop_r;
		write_nxt = write_r;
		bidx_nxt = bidx_r;
		bval_nxt = bval_r;
		wdata_nxt = wdata_r;
		rdata_nxt = rdata_r;
		bank_nxt = bank_r;
		bitarea_nxt = bitarea_r;
		unique case (state_r)
			dmd_pkg::ST_IDLE:
			begin
				if (take)
				begin
					write_nxt = acc_write;
					wdata_nxt = acc_wdata;
					bval_nxt = acc_wbit;
					bidx_nxt = acc_addr[dmd_pkg::BIT_IDX_W-1:0];
					bitop_nxt = 1'b0;
					phys_nxt = acc_addr;
					sfr_nxt = 1'b0;
					unique case (acc_mode)
						// Banked register: bank number above the register number.
						dmd_pkg::ACC_REG:
							phys_nxt = {{dmd_pkg::BANK_PAD_W{1'b0}}, bank_sel, acc_reg};
						// Pointer access always stays in RAM, upper half included.
						dmd_pkg::ACC_INDIRECT:
							sfr_nxt = 1'b0;
						// Upper half is dual-mapped: direct reaches the SFR space.
						dmd_pkg::ACC_DIRECT:
							sfr_nxt = acc_addr[dmd_pkg::HALF_BIT];
						dmd_pkg::ACC_BIT:
						begin
							bitop_nxt = 1'b1;
							sfr_nxt = acc_addr[dmd_pkg::HALF_BIT];
							phys_nxt = acc_addr[dmd_pkg::HALF_BIT]
								? (acc_addr & dmd_pkg::BIT_SFR_MASK)
								: (dmd_pkg::BIT_BASE | (acc_addr >> dmd_pkg::BIT_IDX_W));
						end
					endcase
					state_nxt = dmd_pkg::ST_ACC;
				end
			end
			dmd_pkg::ST_ACC:
			begin
				// Byte writes finish here; reads and bit writes fetch the byte first.
				rdata_nxt = (write_r && !bitop_r) ? wdata_r : rdata_r;
				state_nxt = (write_r && !bitop_r) ? dmd_pkg::ST_RESP : dmd_pkg::ST_READ;
			end
			dmd_pkg::ST_READ:
			begin
				rdata_nxt = rd_byte;
				state_nxt = write_r ? dmd_pkg::ST_WB : dmd_pkg::ST_RESP;
				// Only the addressed bit changes; the rest is written back as read.
				if (write_r)
				begin
					wdata_nxt = bval_r ? (rd_byte | bit_mask) : (rd_byte & ~bit_mask);
				end
			end
			dmd_pkg::ST_WB:
			begin
				rdata_nxt = wdata_r;
				state_nxt = dmd_pkg::ST_RESP;
			end
			dmd_pkg::ST_RESP:
				state_nxt = dmd_pkg::ST_IDLE;
			default:
				state_nxt = dmd_pkg::ST_IDLE;
		endcase
		if (state_r == dmd_pkg::ST_ACC)
		begin
			bank_nxt = !sfr_r && (phys_r < dmd_pkg::BANK_TOP);
			bitarea_nxt = !sfr_r && (phys_r >= dmd_pkg::BIT_BASE) && (phys_r < dmd_pkg::BIT_TOP);
		end
	end

	// Sequencer registers.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_r <= dmd_pkg::ST_IDLE;
			phys_r <= '0;
			sfr_r <= 1'b0;
			bitop_r <= 1'b0;
			write_r <= 1'b0;
			bidx_r <= '0;
			bval_r <= 1'b0;
			wdata_r <= '0;
			rdata_r <= '0;
			bank_r <= 1'b0;
			bitarea_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			phys_r <= phys_nxt;
			sfr_r <= sfr_nxt;
			bitop_r <= bitop_nxt;
			write_r <= write_nxt;
			bidx_r <= bidx_nxt;
			bval_r <= bval_nxt;
			wdata_r <= wdata_nxt;
			rdata_r <= rdata_nxt;
			bank_r <= bank_nxt;
			bitarea_r <= bitarea_nxt;
		end
	end

	// ==================================================================
	// Target strobes, all from registered address and data.
	assign ram_en = !sfr_r && ((state_r == dmd_pkg::ST_ACC) || (state_r == dmd_pkg::ST_WB));
	assign ram_we = ram_en && ((state_r == dmd_pkg::ST_WB) || (write_r && !bitop_r));
	assign sfr_re = sfr_r && (state_r == dmd_pkg::ST_ACC) && !(write_r && !bitop_r);
	assign sfr_we = sfr_r && ((state_r == dmd_pkg::ST_WB)
		|| ((state_r == dmd_pkg::ST_ACC) && write_r && !bitop_r));
	assign sfr_addr = phys_r[dmd_pkg::SFR_AW-1:0];
	assign sfr_wdata = wdata_r;

	// Handshake and response outputs.
	assign acc_ready = (state_r == dmd_pkg::ST_IDLE);
	assign rsp_valid = (state_r == dmd_pkg::ST_RESP);
	assign rsp_data = rdata_r;
	assign rsp_bit = rdata_r[bidx_r];
	assign rsp_sfr = sfr_r;
	assign rsp_in_bank = bank_r;
	assign rsp_in_bitarea = bitarea_r;

	// Full 256-byte RAM; the upper half is only reached by pointer access.
	dmd_ram #(.DW(dmd_pkg::DW), .AW(dmd_pkg::RAM_AW)) u_ram (
		.clk(clk), .nrst(nrst),
		.en(ram_en), .we(ram_we),
		.addr(phys_r), .wdata(wdata_r),
		.rdata_r(ram_rdata)
	);

	// ==================================================================
	// Flash erase gate: only whole sectors, and only inside this variant's size.
	logic fl_go_r, fl_go_nxt, fl_err_r, fl_err_nxt;
	logic [3:0] fl_sector_r, fl_sector_nxt, fl_sector_in;
	logic fl_in_range;

	assign fl_sector_in = fl_erase_addr[dmd_pkg::FLASH_AW-1:dmd_pkg::SECTOR_SHIFT];
	assign fl_in_range = {1'b0, fl_erase_addr} < FLASH_BYTES;

	// Low address bits are dropped, so a request inside a sector erases all of it.
	always_comb
	begin
		fl_go_nxt = fl_erase_req && fl_in_range;
		fl_err_nxt = fl_erase_req && !fl_in_range;
		fl_sector_nxt = fl_go_nxt ? fl_sector_in : fl_sector_r;
	end

	// Flash erase registers.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			fl_go_r <= 1'b0;
			fl_err_r <= 1'b0;
			fl_sector_r <= '0;
		end
		else
		begin
			fl_go_r <= fl_go_nxt;
			fl_err_r <= fl_err_nxt;
			fl_sector_r <= fl_sector_nxt;
		end
	end

	assign fl_erase_go = fl_go_r;
	assign fl_erase_err = fl_err_r;
	assign fl_erase_sector = fl_sector_r;

	// ==================================================================
	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_bit_wr_take;
		take && (acc_mode == dmd_pkg::ACC_BIT) && acc_write;
	endsequence

	sequence s_rmw_walk;
		##1 (state_r == dmd_pkg::ST_ACC) ##1 (state_r == dmd_pkg::ST_READ)
			##1 (state_r == dmd_pkg::ST_WB);
	endsequence

	a_read_latency: assert property (take && !acc_write |-> ##3 rsp_valid)
		else $error("read response not three cycles after acceptance");
	a_upper_ind_ram: assert property (take && (acc_mode == dmd_pkg::ACC_INDIRECT)
		&& acc_addr[7] |=> ram_en && !sfr_re && !sfr_we && phys_r == $past(acc_addr))
		else $error("indirect upper access did not reach RAM");
	a_upper_dir_sfr: assert property (take && (acc_mode == dmd_pkg::ACC_DIRECT)
		&& acc_addr[7] |=> !ram_en && (sfr_re || sfr_we) && {1'b1, sfr_addr} == $past(acc_addr))
		else $error("direct upper access did not reach SFR space");
	a_lower_both_ram: assert property (take && !acc_addr[7]
		&& ((acc_mode == dmd_pkg::ACC_DIRECT) || (acc_mode == dmd_pkg::ACC_INDIRECT))
		|=> ram_en && phys_r == $past(acc_addr))
		else $error("lower half access did not reach RAM");
	a_bank_range: assert property (take && (acc_mode == dmd_pkg::ACC_REG)
		|-> ##2 rsp_in_bank && (rsp_valid == $past(acc_write, 2)))
		else $error("register access fell outside the banks");
	a_bit_only: assert property (s_bit_wr_take |-> s_rmw_walk ##0
		(((wdata_r ^ rdata_r) & ~bit_mask) == 8'h00) && (wdata_r[bidx_r] == bval_r))
		else $error("bit write disturbed other bits");
	a_erase_sector: assert property (fl_erase_req && fl_in_range
		|=> fl_erase_go && fl_erase_sector == $past(fl_sector_in))
		else $error("erase sector wrong or missing");
	a_erase_refuse: assert property (fl_erase_req && !fl_in_range |=> fl_erase_err && !fl_erase_go)
		else $error("out of range erase not refused");
	a_bank_select: assert property (take && (acc_mode == dmd_pkg::ACC_REG)
		|=> ram_en && phys_r == {3'b000, $past(bank_sel), $past(acc_reg)})
		else $error("bank address not formed from bank select");

endmodule

`default_nettype wire

// [test/dmd_sfr_model.sv]
// Behavioural register space that answers the decoder's SFR strobes.
// Assumes one-cycle strobes; read data are wanted the cycle after sfr_re.
`timescale 1ns/1ns
`default_nettype none

module dmd_sfr_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Register space port.
	input wire logic sfr_re,
	input wire logic sfr_we,
	input wire logic [6:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata
);
	logic [7:0] mem [0:127];

	// ==============================================================
	// Storage with one cycle of read latency.
	// Outside a read the lines toggle, so a late sample never sees a stale byte.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sfr_rdata <= 8'h00;
		end
		else
		begin
			if (sfr_we)
			begin
				mem[sfr_addr] <= sfr_wdata;
			end
			sfr_rdata <= sfr_re ? mem[sfr_addr] : ~sfr_rdata;
		end
	end
endmodule

`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the data memory address decoder.
// Assumes the 4 kB flash variant and the register space model beside it.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	logic clk, nrst, acc_valid, acc_ready, acc_write, acc_wbit;
	dmd_pkg::dmd_mode_t acc_mode;
	logic [7:0] acc_addr, acc_wdata, rsp_data, sfr_wdata, sfr_rdata, g_data;
	logic [2:0] acc_reg;
	logic [1:0] bank_sel;
	logic rsp_valid, rsp_bit, rsp_sfr, rsp_in_bank, rsp_in_bitarea;
	logic sfr_re, sfr_we, fl_erase_req, fl_erase_go, fl_erase_err;
	logic [6:0] sfr_addr;
	logic [12:0] fl_erase_addr;
	logic [3:0] fl_erase_sector;
	int miscompares, n_tests;

	dmd_decoder #(.FLASH_BYTES(14'h1000)) i_dmd_decoder (.clk(clk), .nrst(nrst),
		.acc_valid(acc_valid), .acc_ready(acc_ready), .acc_mode(acc_mode),
		.acc_addr(acc_addr), .acc_reg(acc_reg), .acc_write(acc_write),
		.acc_wdata(acc_wdata), .acc_wbit(acc_wbit), .bank_sel(bank_sel),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_bit(rsp_bit), .rsp_sfr(rsp_sfr),
		.rsp_in_bank(rsp_in_bank), .rsp_in_bitarea(rsp_in_bitarea), .sfr_re(sfr_re),
		.sfr_we(sfr_we), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.fl_erase_req(fl_erase_req), .fl_erase_addr(fl_erase_addr),
		.fl_erase_go(fl_erase_go), .fl_erase_sector(fl_erase_sector),
		.fl_erase_err(fl_erase_err));

	dmd_sfr_model i_dmd_sfr_model (.clk(clk), .nrst(nrst), .sfr_re(sfr_re),
		.sfr_we(sfr_we), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));

	// ==============================================================
	// Free-running 125 MHz clock.
	always #4 clk = ~clk;

	task automatic give_verdict;
		if (miscompares == 0 && n_tests > 0)
		begin
			$display("Run complete: PASS");
		end
		else
		begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask

	// ==============================================================
	// One core access, started and ended at a falling edge; the request
	// stands until an edge that sees ready, so nothing is lost to a refusal.
	task automatic acc(input dmd_pkg::dmd_mode_t m, input logic [7:0] a,
		input logic [2:0] r, input logic w, input logic [7:0] d, input logic b);
		int n;
		n = 0;
		acc_mode = m;
		acc_addr = a;
		acc_reg = r;
		acc_write = w;
		acc_wdata = d;
		acc_wbit = b;
		acc_valid = 1'b1;
		while (acc_ready !== 1'b1 && n < 40)
		begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		acc_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 40)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 40)
		begin
			miscompares++;
			give_verdict();
		end
		g_data = rsp_data;
	endtask

	// Both halves, direct and indirect, with the boundary bytes.
	task automatic t_halves;
		acc(dmd_pkg::ACC_DIRECT, 8'h7F, 3'h0, 1'b1, 8'h5A, 1'b0);
		acc(dmd_pkg::ACC_INDIRECT, 8'h7F, 3'h0, 1'b0, 8'h00, 1'b0);
		chk8(g_data, 8'h5A);
		chk8({rsp_sfr, rsp_in_bank, rsp_in_bitarea}, 8'h00);
		acc(dmd_pkg::ACC_INDIRECT, 8'h80, 3'h0, 1'b1, 8'hA5, 1'b0);
		acc(dmd_pkg::ACC_DIRECT, 8'h80, 3'h0, 1'b1, 8'h3C, 1'b0);
		acc(dmd_pkg::ACC_INDIRECT, 8'h80, 3'h0, 1'b0, 8'h00, 1'b0);
		chk8({g_data[6:0], rsp_sfr}, {7'h25, 1'b0});
		acc(dmd_pkg::ACC_DIRECT, 8'h80, 3'h0, 1'b0, 8'h00, 1'b0);
		chk8({g_data[6:0], rsp_sfr}, {7'h3C, 1'b1});
	endtask

	// Every bank, written by register number and read back by byte address.
	task automatic t_banks;
		for (int b = 0; b < 4; b++)
		begin
			bank_sel = 2'(b);
			acc(dmd_pkg::ACC_REG, 8'h00, 3'(7 - b), 1'b1, 8'(8'h50 + b), 1'b0);
			bank_sel = 2'(3 - b);
			acc(dmd_pkg::ACC_DIRECT, {3'b000, 2'(b), 3'(7 - b)}, 3'h0, 1'b0, 8'h00, 1'b0);
			chk8(g_data, 8'(8'h50 + b));
			chk8({rsp_in_bank, rsp_in_bitarea}, 8'h02);
			bank_sel = 2'(b);
			acc(dmd_pkg::ACC_REG, 8'h00, 3'(7 - b), 1'b0, 8'h00, 1'b0);
			chk8(g_data, 8'(8'h50 + b));
		end
	endtask

	// Single-bit writes and reads in RAM and in the register space.
	task automatic t_bits;
		acc(dmd_pkg::ACC_DIRECT, 8'h21, 3'h0, 1'b1, 8'h81, 1'b0);
		acc(dmd_pkg::ACC_BIT, 8'h0B, 3'h0, 1'b1, 8'h00, 1'b1);
		chk8(g_data, 8'h89);
		chk8(rsp_in_bitarea, 8'h01);
		acc(dmd_pkg::ACC_BIT, 8'h08, 3'h0, 1'b1, 8'h00, 1'b0);
		acc(dmd_pkg::ACC_BIT, 8'h0F, 3'h0, 1'b0, 8'h00, 1'b0);
		chk8(rsp_bit, 8'h01);
		acc(dmd_pkg::ACC_DIRECT, 8'h21, 3'h0, 1'b0, 8'h00, 1'b0);
		chk8(g_data, 8'h88);
		acc(dmd_pkg::ACC_BIT, 8'h83, 3'h0, 1'b0, 8'h00, 1'b0);
		chk8({rsp_bit, rsp_sfr}, 8'h03);
		acc(dmd_pkg::ACC_BIT, 8'h81, 3'h0, 1'b1, 8'h00, 1'b1);
		chk8({rsp_sfr, rsp_in_bitarea}, 8'h02);
		acc(dmd_pkg::ACC_DIRECT, 8'h80, 3'h0, 1'b0, 8'h00, 1'b0);
		chk8(g_data, 8'h3E);
	endtask

	// Back-to-back erase requests across sector edges and past the top.
	task automatic t_flash;
		logic [12:0] fa [4];
		fa = '{13'h01FF, 13'h0200, 13'h0FFF, 13'h1000};
		for (int i = 0; i < 5; i++)
		begin
			if (i > 0)
			begin
				chk8({fl_erase_go, fl_erase_err}, (fa[i - 1] < 13'h1000) ? 8'h02 : 8'h01);
			end
			if (i > 0 && fa[i - 1] < 13'h1000)
			begin
				chk8(fl_erase_sector, 8'(fa[i - 1][12:9]));
			end
			fl_erase_req = (i < 4);
			fl_erase_addr = fa[i % 4];
			@(negedge clk);
		end
	endtask

	// ==============================================================
	// Main sequence: reset for six cycles, then each scenario in turn.
	initial
	begin
		clk = 1'b0;
		nrst = 1'b0;
		acc_valid = 1'b0;
		acc_mode = dmd_pkg::ACC_DIRECT;
		acc_addr = 8'h00;
		acc_reg = 3'h0;
		acc_write = 1'b0;
		acc_wdata = 8'h00;
		acc_wbit = 1'b0;
		bank_sel = 2'h0;
		fl_erase_req = 1'b0;
		fl_erase_addr = 13'h0000;
		miscompares = 0;
		n_tests = 0;
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		chk8({acc_ready, rsp_valid}, 8'h02);
		t_halves();
		t_banks();
		t_bits();
		t_flash();
		give_verdict();
	end
endmodule

`default_nettype wire
